// *** hw/cmp_ctrl.sv ***
// Purpose: Comparator input select, polarity and result register.
// Assumes: Raw comparator outputs are asynchronous to I_CLK.
// Notes: Result bits are read only; writes to them are ignored.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module cmp_ctrl (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [31:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [31:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_CMP_ONE_RAW,
  input wire logic I_CMP_TWO_RAW,
  output logic O_CMP_ONE_POS_SEL,
  output logic O_CMP_ONE_NEG_SEL,
  output logic O_CMP_TWO_POS_SEL,
  output logic O_CMP_TWO_NEG_SEL,
  output logic O_CMP_ONE_OUT,
  output logic O_CMP_TWO_OUT,
  output logic O_CMP_ONE_OEN,
  output logic O_CMP_TWO_OEN
);
  import cmp_ctrl_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] ctrl_r;        // Control bits as written
  logic aw_held_r;            // Write address captured
  logic w_held_r;             // Write data captured
  logic [31:0] awaddr_r;      // Captured write address
  logic [31:0] wdata_r;       // Captured write data
  logic [3:0] wstrb_r;        // Captured strobes
  logic [1:0] cmp_raw;        // Raw comparator levels, bit 0 is comparator one
  logic [1:0] cmp_sync;       // Same levels after the two-flop chains
  logic cmp_one_sync;         // Synchronised raw outputs
  logic cmp_two_sync;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  assign cmp_raw = {I_CMP_TWO_RAW, I_CMP_ONE_RAW};
  assign cmp_one_sync = cmp_sync[0];
  assign cmp_two_sync = cmp_sync[1];

  // One chain per comparator
  for (genvar g = 0; g < $bits(cmp_raw); g++) begin : g_sync
    cmp_sync2 u_sync (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_d(cmp_raw[g]),
      .o_q(cmp_sync[g])
    );
  end

  // ----------------------------------------
  // Polarity and result
  // ----------------------------------------
  // Raw is 1 when plus input exceeds minus input
  wire cmp_one_result = cmp_one_sync ^ ctrl_r[C1_INV_BIT];
  wire cmp_two_result = cmp_two_sync ^ ctrl_r[C2_INV_BIT];

  // Read view with live result bits
  // Result positions are never written, so the live bits can be merged in
  wire [15:0] ctrl_view = ctrl_r | (16'(cmp_one_result) << C1_OUT_BIT)
    | (16'(cmp_two_result) << C2_OUT_BIT);

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire wr_go = aw_held_r && w_held_r && !O_BVALID;
  wire wr_hit = (awaddr_r[3:2] == CTRL_ADDR[3:2]) && (awaddr_r[31:4] == 28'h0);
  wire [15:0] byte_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}} & CTRL_WMASK;
  wire [15:0] ctrl_nxt = (ctrl_r & ~byte_mask) | (wdata_r[15:0] & byte_mask);
  wire rd_hit = (I_ARADDR[3:2] == CTRL_ADDR[3:2]) && (I_ARADDR[31:4] == 28'h0);
  wire rd_go = I_ARVALID && O_ARREADY;

  // ----------------------------------------
  // Write channel capture
  // ----------------------------------------
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 32'h0;
    end else if (I_AWVALID && O_AWREADY) begin
      aw_held_r <= 1'b1;
      awaddr_r <= I_AWADDR;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else if (I_WVALID && O_WREADY) begin
      w_held_r <= 1'b1;
      wdata_r <= I_WDATA;
      wstrb_r <= I_WSTRB;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // Ready high while nothing held and no response pending
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
    end else begin
      O_AWREADY <= !aw_held_r && !(I_AWVALID && O_AWREADY) && !O_BVALID && !wr_go;
      O_WREADY <= !w_held_r && !(I_WVALID && O_WREADY) && !O_BVALID && !wr_go;
    end
  end

  // ----------------------------------------
  // Control register and response
  // ----------------------------------------
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_go && wr_hit) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end else if (wr_go) begin
      O_BVALID <= 1'b1;
      O_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0;
      O_RRESP <= RESP_OKAY;
    end else if (rd_go) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RDATA <= rd_hit ? {16'h0, ctrl_view} : 32'h0;
      O_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (O_RVALID) begin
      if (I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end else begin
      O_ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------
  // Outputs to the analog side
  // ----------------------------------------
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_CMP_ONE_POS_SEL <= 1'b0;
      O_CMP_ONE_NEG_SEL <= 1'b0;
      O_CMP_TWO_POS_SEL <= 1'b0;
      O_CMP_TWO_NEG_SEL <= 1'b0;
      O_CMP_ONE_OUT <= 1'b0;
      O_CMP_TWO_OUT <= 1'b0;
      O_CMP_ONE_OEN <= 1'b0;
      O_CMP_TWO_OEN <= 1'b0;
    end else begin
      O_CMP_ONE_POS_SEL <= ctrl_r[C1_POS_BIT];
      O_CMP_ONE_NEG_SEL <= ctrl_r[C1_NEG_BIT];
      O_CMP_TWO_POS_SEL <= ctrl_r[C2_POS_BIT];
      O_CMP_TWO_NEG_SEL <= ctrl_r[C2_NEG_BIT];
      O_CMP_ONE_OUT <= cmp_one_result;
      O_CMP_TWO_OUT <= cmp_two_result;
      // Pin mapping is left to software
      O_CMP_ONE_OEN <= ctrl_r[C1_OEN_BIT];
      O_CMP_TWO_OEN <= ctrl_r[C2_OEN_BIT];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_one_polarity: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !ctrl_r[C1_INV_BIT] && !$changed(ctrl_r) |=> O_CMP_ONE_OUT == $past(cmp_one_sync))
    else $error("comparator one result wrong with normal polarity");
  chk_one_inverted: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    ctrl_r[C1_INV_BIT] |=> O_CMP_ONE_OUT == !$past(cmp_one_sync))
    else $error("comparator one result wrong when inverted");
  chk_one_readback: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    rd_go && rd_hit |=> O_RDATA[C1_OUT_BIT] == ($past(cmp_one_sync) ^ $past(ctrl_r[C1_INV_BIT])))
    else $error("comparator one read bit mismatch");
  chk_two_polarity: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    1'b1 |=> O_CMP_TWO_OUT == ($past(cmp_two_sync) ^ $past(ctrl_r[C2_INV_BIT])))
    else $error("comparator two polarity wrong");
  chk_two_neg_sel: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wr_go && wr_hit && wstrb_r[0] |=> ##1 O_CMP_TWO_NEG_SEL == $past(wdata_r[C2_NEG_BIT], 2))
    else $error("comparator two minus select not applied");
  chk_two_pos_sel: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wr_go && wr_hit && wstrb_r[0] |=> ##1 O_CMP_TWO_POS_SEL == $past(wdata_r[C2_POS_BIT], 2))
    else $error("comparator two plus select not applied");
  chk_one_neg_sel: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wr_go && wr_hit && wstrb_r[0] |=> ##1 O_CMP_ONE_NEG_SEL == $past(wdata_r[C1_NEG_BIT], 2))
    else $error("comparator one minus select not applied");
  chk_one_pos_sel: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wr_go && wr_hit && wstrb_r[0] |=> ##1 O_CMP_ONE_POS_SEL == $past(wdata_r[C1_POS_BIT], 2))
    else $error("comparator one plus select not applied");
  chk_sync_delay: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $rose(cmp_one_sync) |-> $past(I_CMP_ONE_RAW, 2))
    else $error("comparator one synchroniser depth wrong");
endmodule : cmp_ctrl

// *** hw/cmp_ctrl_pkg.sv ***
// Purpose: Constants for the dual comparator control block.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes: Field positions of the comparator control word.
// Notes on behaviour
// - Normal polarity: result 1 when plus exceeds minus
// - Inverted polarity: result 0 when plus exceeds minus
// - Comparator one invert bit flips its output
// - Comparator two invert bit flips its output
// - Comparator two minus input: plus or minus pin
// - Comparator two plus input: plus pin or reference
// - Comparator one minus input: plus or minus pin
// - Comparator one plus input: plus pin or reference
package cmp_ctrl_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h0;   // Comparator control word
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hc03f; // Writable bits
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int C1_POS_BIT = 0;
  localparam int C1_NEG_BIT = 1;
  localparam int C2_POS_BIT = 2;
  localparam int C2_NEG_BIT = 3;
  localparam int C1_INV_BIT = 4;
  localparam int C2_INV_BIT = 5;
  localparam int C1_OUT_BIT = 6;
  localparam int C2_OUT_BIT = 7;
  localparam int C1_OEN_BIT = 14;
  localparam int C2_OEN_BIT = 15;
  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cmp_ctrl_pkg

// *** hw/cmp_sync2.sv ***
// Purpose: Two-flop synchroniser for one asynchronous level.
// Assumes: Input is from outside the clock domain.
// Notes: First flop feeds only the second.
`timescale 1ns/10ps
module cmp_sync2 (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);
  logic meta_r; // First stage, read only by second
  // ----------------------------------------
  // Synchroniser chain
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule : cmp_sync2

// *** test/cmp_analog_model.sv ***
// Purpose: Behavioural analog side: input routing and two comparators.
// Assumes: Pin and reference levels are plain unsigned millivolt codes.
// Notes: Equal inputs give a low raw output.
`timescale 1ns/10ps
module cmp_analog_model (
  input wire logic i_one_pos_sel,
  input wire logic i_one_neg_sel,
  input wire logic i_two_pos_sel,
  input wire logic i_two_neg_sel,
  input wire logic [7:0] i_v_plus,
  input wire logic [7:0] i_v_minus,
  input wire logic [7:0] i_v_ref,
  output logic o_one_raw,
  output logic o_two_raw
);
  // Routed inputs of each comparator
  logic [7:0] one_p, one_n, two_p, two_n;
  assign one_p = i_one_pos_sel ? i_v_plus : i_v_ref;
  assign one_n = i_one_neg_sel ? i_v_plus : i_v_minus;
  assign two_p = i_two_pos_sel ? i_v_plus : i_v_ref;
  assign two_n = i_two_neg_sel ? i_v_plus : i_v_minus;
  // Raw results, asynchronous to the bus clock
  assign o_one_raw = one_p > one_n;
  assign o_two_raw = two_p > two_n;
endmodule : cmp_analog_model

// *** test/cmp_ctrl_tb.sv ***
// Purpose: Self-checking bench for the comparator control block.
// Assumes: AXI4-Lite master tasks; analog side from the behavioural model.
// Notes: Result latency is three edges, so reads wait six cycles.
`timescale 1ns/10ps
module cmp_ctrl_tb;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, raw1, raw2;
  logic p1, n1, p2, n2, o1, o2, e1, e2;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [7:0] vp, vm, vr;
  int err_total, check_count;
  // Design and analog side
  cmp_ctrl i_cmp_ctrl (.I_CLK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_CMP_ONE_RAW(raw1),
    .I_CMP_TWO_RAW(raw2), .O_CMP_ONE_POS_SEL(p1), .O_CMP_ONE_NEG_SEL(n1),
    .O_CMP_TWO_POS_SEL(p2), .O_CMP_TWO_NEG_SEL(n2), .O_CMP_ONE_OUT(o1),
    .O_CMP_TWO_OUT(o2), .O_CMP_ONE_OEN(e1), .O_CMP_TWO_OEN(e2));
  cmp_analog_model i_cmp_analog_model (.i_one_pos_sel(p1), .i_one_neg_sel(n1),
    .i_two_pos_sel(p2), .i_two_neg_sel(n2), .i_v_plus(vp), .i_v_minus(vm),
    .i_v_ref(vr), .o_one_raw(raw1), .o_two_raw(raw2));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic results();
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // A wait that ran out counts as a mismatch
  task automatic tmo();
    err_total++;
    results();
  endtask : tmo
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Write: address and data together, each dropped when taken
  task automatic wr(input logic [31:0] a, dt, input logic [3:0] s, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dt;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      if (n > 60) tmo();
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  // Read: address held until taken, data taken with rvalid
  task automatic rd(input logic [31:0] a, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 60) tmo();
    end while (!rvalid);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'h0;
    vp = 8'hc8;
    vm = 8'h64;
    vr = 8'h32;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(32'h0, d, r);
    chk(d, 32'h0);
    // Each select bit drives its own routing output
    for (int b = 0; b < 4; b++) begin
      wr(32'h0, 32'h1 << b, 4'h3, r);
      repeat (2) @(posedge clk);
      #1 chk({28'h0, n2, p2, n1, p1}, 32'h1 << b);
    end
    // Enables, then a low-byte-only write
    wr(32'h0, 32'h0000c000, 4'h3, r);
    chk(r, 32'h0);
    repeat (2) @(posedge clk);
    // Enabled outputs stand ready for the pin mapping software sets up
    #1 chk({30'h0, e2, e1}, 32'h3);
    wr(32'h0, 32'hffff0003, 4'h1, r);
    rd(32'h0, d, r);
    chk(d, 32'h0000c003);
    // Unmapped word: error, write ignored
    wr(32'h4, 32'hffff, 4'h3, r);
    chk(r, 32'h2);
    rd(32'h4, d, r);
    chk({r, d[29:0]}, 32'h80000000);
    rd(32'h0, d, r);
    chk(d, 32'h0000c003);
    // Both polarities against both input orders; result bits not writable
    for (int k = 0; k < 8; k++) begin
      vr <= k[2] ? 8'h96 : 8'h32;
      wr(32'h0, {24'h0, 2'b11, k[1:0], 4'h0}, 4'h3, r);
      repeat (6) @(posedge clk);
      #1 chk({o2, o1}, {k[2] ^ k[1], k[2] ^ k[0]});
      rd(32'h0, d, r);
      chk(d, {24'h0, k[2] ^ k[1], k[2] ^ k[0], k[1:0], 4'h0});
    end
    // Synchroniser: outputs hold for two edges, move on the third
    @(posedge clk);
    vr <= 8'h32;
    repeat (2) @(posedge clk);
    #1 chk({30'h0, o2, o1}, 32'h0);
    @(posedge clk);
    #1 chk({30'h0, o2, o1}, 32'h3);
    results();
  end
endmodule : cmp_ctrl_tb
